// File: inc/tadc_pkg.sv
// Constants shared by the touch ADC serial port design files.
// Assumes that a single 12-bit result and a 7-bit control tail are used.
package tadc_pkg;

   // Widths of the result word and of the control bits after the start bit.
   localparam int RESULT_BITS = 12;
   localparam int CTRL_BITS   = 7;

   // Index of the last control bit, counted from zero after the start bit.
   localparam logic [2:0] CTRL_LAST_IDX = 3'h6;

   // Falling-edge numbers, counted from the start bit, and the acquisition length in cycles.
   localparam logic [4:0] ACQ_FIRST_EDGE = 5'h05;
   localparam logic [4:0] ACQ_CYCLES     = 5'h03;
   localparam logic [4:0] HOLD_EDGE      = 5'(ACQ_FIRST_EDGE + ACQ_CYCLES);
   localparam logic [4:0] FIRST_BIT_EDGE = 5'(HOLD_EDGE + 5'h01);
   localparam logic [4:0] FRAME_END_EDGE = 5'(HOLD_EDGE + 5'h0C);

   // Field positions inside the captured 7-bit control word.
   localparam int CTRL_ADDR_MSB = 6;
   localparam int CTRL_ADDR_LSB = 4;
   localparam int CTRL_MODE_POS = 3;
   localparam int CTRL_SER_POS  = 2;
   localparam int CTRL_PD_MSB   = 1;
   localparam int CTRL_PD_LSB   = 0;

   // Values after reset.
   localparam logic [11:0] RESULT_RST = 12'h000;
   localparam logic [6:0]  CTRL_RST   = 7'h00;

endpackage

// File: inc/tadc_word_if.sv
// Word transfer bundle between two clock domains of the touch ADC port.
// Assumes one side loads words and the other side only receives them.
`timescale 1ns/1ps
interface tadc_word_if #(
   parameter int W = 8
);
   logic [W-1:0] src_data;
   logic         src_load;
   logic         src_busy;
   logic [W-1:0] dst_data;
   logic         dst_strobe;

   // The crossing logic takes words in and hands them out.
   modport xfer (
      input  src_data,
      input  src_load,
      output src_busy,
      output dst_data,
      output dst_strobe
   );

   // The user loads on one clock and receives on the other.
   modport user (
      output src_data,
      output src_load,
      input  src_busy,
      input  dst_data,
      input  dst_strobe
   );
endinterface

// File: core/tadc_word_cdc.sv
// Toggle handshake that carries one word from a source to a destination
// clock. Assumes the source holds off new loads while src_busy is high.
`timescale 1ns/1ps
module tadc_word_cdc (
   input  wire logic  src_clk_i,
   input  wire logic  src_nrst_i,
   input  wire logic  dst_clk_i,
   input  wire logic  dst_nrst_i,
   tadc_word_if.xfer  port_x
);
   localparam int W = $bits(port_x.src_data);

   logic         req_tgl;
   logic         next_req_tgl;
   logic [W-1:0] hold;
   logic [W-1:0] next_hold;
   logic         ack_s1;
   logic         ack_s2;
   logic         req_s1;
   logic         req_s2;
   logic         req_s3;
   logic [W-1:0] dst_data;
   logic [W-1:0] next_dst_data;
   logic         dst_strobe;
   logic         next_dst_strobe;

   // The hold word stays still until the destination has echoed the toggle.
   assign port_x.src_busy = req_tgl ^ ack_s2;

   // Source side: a load while idle captures the word and flips the request.
   always_comb begin
      next_req_tgl = req_tgl;
      next_hold    = hold;
      if (port_x.src_load && !port_x.src_busy) begin
         next_req_tgl = ~req_tgl;
         next_hold    = port_x.src_data;
      end
   end

   // Source registers, including the two-stage acknowledge synchroniser.
   always_ff @(posedge src_clk_i or negedge src_nrst_i) begin
      if (!src_nrst_i) begin
         req_tgl <= 1'b0;
         hold    <= '0;
         ack_s1  <= 1'b0;
         ack_s2  <= 1'b0;
      end else begin
         req_tgl <= next_req_tgl;
         hold    <= next_hold;
         ack_s1  <= req_s3;
         ack_s2  <= ack_s1;
      end
   end

   // Destination side: a toggle seen past the synchroniser takes the word.
   always_comb begin
      next_dst_strobe = req_s2 ^ req_s3;
      next_dst_data   = next_dst_strobe ? hold : dst_data;
   end

   // Destination registers; req_s3 doubles as the returned acknowledge.
   always_ff @(posedge dst_clk_i or negedge dst_nrst_i) begin
      if (!dst_nrst_i) begin
         req_s1     <= 1'b0;
         req_s2     <= 1'b0;
         req_s3     <= 1'b0;
         dst_data   <= '0;
         dst_strobe <= 1'b0;
      end else begin
         req_s1     <= req_tgl;
         req_s2     <= req_s1;
         req_s3     <= req_s2;
         dst_data   <= next_dst_data;
         dst_strobe <= next_dst_strobe;
      end
   end

   assign port_x.dst_data   = dst_data;
   assign port_x.dst_strobe = dst_strobe;

endmodule

// File: core/tadc_serial_port.sv
// Serial port and conversion timing front end of a touch screen ADC.
// Assumes the host serial clock runs through each frame and may stop
// while chip select is high; the SAR core delivers samples on clk_sys_i.
`timescale 1ns/1ps
module tadc_serial_port (
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   input  wire logic        host_serial_clock_i,
   input  wire logic        chip_select_n_i,
   input  wire logic        serial_din_i,
   output logic             serial_dout_o,
   output logic             serial_dout_oe_o,
   output logic             busy_o,
   output logic             busy_oe_o,
   output logic             touch_detect_irq_n_o,
   output logic             touch_detect_irq_n_oe_o,
   input  wire logic        pen_touch_i,
   input  wire logic [11:0] adc_sample_i,
   input  wire logic        adc_sample_valid_i,
   output logic             adc_sample_ready_o,
   output logic             track_hold_o,
   output logic [2:0]       channel_addr_o,
   output logic             single_ended_select_o,
   output logic             low_res_mode_o,
   output logic [1:0]       power_mode_o,
   output logic             ctrl_strobe_o
);

   typedef enum logic [1:0] {
      TADC_IDLE = 2'b00,
      TADC_CTRL = 2'b01,
      TADC_CONV = 2'b10
   } tadc_link_state_t;

   tadc_word_if #(.W(tadc_pkg::RESULT_BITS)) sample_x ();
   tadc_word_if #(.W(tadc_pkg::CTRL_BITS))   ctrl_x ();

   logic             link_nrst;
   tadc_link_state_t state;
   tadc_link_state_t next_state;
   logic [2:0]       rcnt;
   logic [2:0]       next_rcnt;
   logic [6:0]       ctrl_sr;
   logic [6:0]       next_ctrl_sr;
   logic [4:0]       fcnt;
   logic [4:0]       next_fcnt;
   logic             dout_q;
   logic             next_dout_q;
   logic             busy_q;
   logic             next_busy_q;
   logic             track_q;
   logic             next_track_q;
   logic [11:0]      res_sr;
   logic [11:0]      next_res_sr;
   logic [11:0]      sample_word;
   logic [11:0]      next_sample_word;
   logic             pen_s1;
   logic             pen_s2;
   logic [6:0]       ctrl_word;
   logic [6:0]       next_ctrl_word;
   logic             ctrl_strobe;

   // Chip select high clears the whole link engine at once.
   assign link_nrst = nrst_i & ~chip_select_n_i;

   // Samples from the SAR core cross to the serial clock by handshake.
   assign sample_x.src_data  = adc_sample_i;
   assign sample_x.src_load  = adc_sample_valid_i;
   assign adc_sample_ready_o = ~sample_x.src_busy;

   tadc_word_cdc u_sample_cdc (
      .src_clk_i  (clk_sys_i),
      .src_nrst_i (nrst_i),
      .dst_clk_i  (host_serial_clock_i),
      .dst_nrst_i (nrst_i),
      .port_x     (sample_x)
   );

   // The finished control word crosses back to the system clock.
   assign ctrl_x.src_data = {ctrl_sr[5:0], serial_din_i};
   assign ctrl_x.src_load = (state == TADC_CTRL) &&
                            (rcnt == tadc_pkg::CTRL_LAST_IDX);

   tadc_word_cdc u_ctrl_cdc (
      .src_clk_i  (host_serial_clock_i),
      .src_nrst_i (nrst_i),
      .dst_clk_i  (clk_sys_i),
      .dst_nrst_i (nrst_i),
      .port_x     (ctrl_x)
   );

   // Rising edge side: waits for the start bit, then shifts control bits.
   always_comb begin
      next_state   = state;
      next_rcnt    = rcnt;
      next_ctrl_sr = ctrl_sr;
      unique case (state)
         TADC_IDLE: begin
            if (serial_din_i) begin
               next_state = TADC_CTRL;
               next_rcnt  = 3'h0;
            end
         end
         TADC_CTRL: begin
            next_ctrl_sr = {ctrl_sr[5:0], serial_din_i};
            next_rcnt    = 3'(rcnt + 3'h1);
            if (rcnt == tadc_pkg::CTRL_LAST_IDX) begin
               next_state = TADC_CONV;
            end
         end
         TADC_CONV: begin
            if (fcnt >= tadc_pkg::FRAME_END_EDGE) begin
               next_state = TADC_IDLE;
            end
         end
         default: begin
            next_state = TADC_IDLE;
         end
      endcase
   end

   // Rising edge registers of the link.
   always_ff @(posedge host_serial_clock_i or negedge link_nrst) begin
      if (!link_nrst) begin
         state   <= TADC_IDLE;
         rcnt    <= 3'h0;
         ctrl_sr <= tadc_pkg::CTRL_RST;
      end else begin
         state   <= next_state;
         rcnt    <= next_rcnt;
         ctrl_sr <= next_ctrl_sr;
      end
   end

   // Latest sample delivered from the system clock, kept across frames.
   always_comb begin
      next_sample_word = sample_x.dst_strobe ? sample_x.dst_data
                                             : sample_word;
   end

   always_ff @(posedge host_serial_clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sample_word <= tadc_pkg::RESULT_RST;
      end else begin
         sample_word <= next_sample_word;
      end
   end

   // Falling edge side: counts edges from the start bit and times the
   // acquisition window, the hold and the result shift.
   always_comb begin
      next_fcnt    = (state == TADC_IDLE) ? 5'h00 : 5'(fcnt + 5'h01);
      next_track_q = track_q;
      next_busy_q  = 1'b0;
      next_dout_q  = 1'b0;
      next_res_sr  = res_sr;
      if (next_fcnt == tadc_pkg::ACQ_FIRST_EDGE) begin
         next_track_q = 1'b1;
      end
      if (next_fcnt == tadc_pkg::HOLD_EDGE) begin
         next_track_q = 1'b0;
         next_busy_q  = 1'b1;
         next_res_sr  = sample_word;
      end
      if (next_fcnt >= tadc_pkg::FIRST_BIT_EDGE) begin
         next_dout_q = res_sr[11];
         next_res_sr = {res_sr[10:0], 1'b0};
      end
   end

   // Falling edge registers of the link.
   always_ff @(negedge host_serial_clock_i or negedge link_nrst) begin
      if (!link_nrst) begin
         fcnt    <= 5'h00;
         track_q <= 1'b0;
         busy_q  <= 1'b0;
         dout_q  <= 1'b0;
         res_sr  <= tadc_pkg::RESULT_RST;
      end else begin
         fcnt    <= next_fcnt;
         track_q <= next_track_q;
         busy_q  <= next_busy_q;
         dout_q  <= next_dout_q;
         res_sr  <= next_res_sr;
      end
   end

   // Pin drivers; the enables follow chip select directly.
   assign serial_dout_o    = dout_q;
   assign serial_dout_oe_o = ~chip_select_n_i;
   assign busy_o           = busy_q;
   assign busy_oe_o        = ~chip_select_n_i;
   assign track_hold_o     = track_q;

   // Pen detect synchroniser; the pin is only ever pulled low.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pen_s1 <= 1'b0;
         pen_s2 <= 1'b0;
      end else begin
         pen_s1 <= pen_touch_i;
         pen_s2 <= pen_s1;
      end
   end

   assign touch_detect_irq_n_o    = 1'b0;
   assign touch_detect_irq_n_oe_o = pen_s2;

   // Control fields land on the system clock when a word has crossed.
   always_comb begin
      next_ctrl_word = ctrl_x.dst_strobe ? ctrl_x.dst_data : ctrl_word;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_word   <= tadc_pkg::CTRL_RST;
         ctrl_strobe <= 1'b0;
      end else begin
         ctrl_word   <= next_ctrl_word;
         ctrl_strobe <= ctrl_x.dst_strobe;
      end
   end

   assign channel_addr_o =
      ctrl_word[tadc_pkg::CTRL_ADDR_MSB:tadc_pkg::CTRL_ADDR_LSB];
   assign single_ended_select_o = ctrl_word[tadc_pkg::CTRL_SER_POS];
   assign low_res_mode_o        = ctrl_word[tadc_pkg::CTRL_MODE_POS];
   assign power_mode_o  =
      ctrl_word[tadc_pkg::CTRL_PD_MSB:tadc_pkg::CTRL_PD_LSB];
   assign ctrl_strobe_o = ctrl_strobe;

   // Checks on the pins and on the link timing.
   property p_dout_hiz;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      chip_select_n_i |-> !serial_dout_oe_o;
   endproperty
   a_dout_hiz: assert property (p_dout_hiz)
      else $error("Result output driven while chip select is high.");

   property p_busy_hiz;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      busy_oe_o == !chip_select_n_i;
   endproperty
   a_busy_hiz: assert property (p_busy_hiz)
      else $error("Busy enable does not follow chip select.");

   property p_cs_idle;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      chip_select_n_i |-> (state == TADC_IDLE && fcnt == 5'h00 && !busy_q);
   endproperty
   a_cs_idle: assert property (p_cs_idle)
      else $error("Link engine active while chip select is high.");

   property p_ctrl_capture;
      @(posedge host_serial_clock_i) disable iff (!link_nrst)
      (state == TADC_CTRL) |=> (ctrl_sr[0] == $past(serial_din_i));
   endproperty
   a_ctrl_capture: assert property (p_ctrl_capture)
      else $error("Control bit not captured on the rising edge.");

   property p_start_wait;
      @(posedge host_serial_clock_i) disable iff (!link_nrst)
      (state == TADC_IDLE && !serial_din_i) |=> (state == TADC_IDLE);
   endproperty
   a_start_wait: assert property (p_start_wait)
      else $error("Low sample taken as a start bit.");

   property p_acq_start;
      @(negedge host_serial_clock_i) disable iff (!link_nrst)
      $rose(track_q) |-> (fcnt == tadc_pkg::ACQ_FIRST_EDGE);
   endproperty
   a_acq_start: assert property (p_acq_start)
      else $error("Acquisition began on the wrong falling edge.");

   property p_acq_len;
      @(negedge host_serial_clock_i) disable iff (!link_nrst)
      $rose(track_q) |-> track_q[*3] ##1 !track_q;
   endproperty
   a_acq_len: assert property (p_acq_len)
      else $error("Acquisition window is not three cycles long.");

   property p_hold_busy;
      @(negedge host_serial_clock_i) disable iff (!link_nrst)
      $rose(track_q) |-> ##3 (busy_q && !track_q) ##1 !busy_q;
   endproperty
   a_hold_busy: assert property (p_hold_busy)
      else $error("Busy does not follow the acquisition window.");

   property p_msb_first;
      @(negedge host_serial_clock_i) disable iff (!link_nrst)
      $rose(busy_q) |=> (dout_q == $past(res_sr[11]));
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("First result bit is not the MSB.");

   property p_trailing_zero;
      @(negedge host_serial_clock_i) disable iff (!link_nrst)
      $rose(busy_q) |-> ##13 !dout_q;
   endproperty
   a_trailing_zero: assert property (p_trailing_zero)
      else $error("Bit after the LSB is not zero.");

   property p_pen_drive;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (touch_detect_irq_n_oe_o == $past(pen_touch_i, 2)) &&
      !touch_detect_irq_n_o;
   endproperty
   a_pen_drive: assert property (p_pen_drive)
      else $error("Pen interrupt pin not driven as open drain.");

   c_frame: cover property (@(negedge host_serial_clock_i)
      disable iff (!link_nrst) $rose(busy_q) ##13 (state == TADC_IDLE));
   c_ctrl_cross: cover property (@(posedge clk_sys_i)
      disable iff (!nrst_i) ctrl_strobe);
   c_pen: cover property (@(posedge clk_sys_i)
      disable iff (!nrst_i) $rose(touch_detect_irq_n_oe_o));

endmodule

// File: sim/tadc_host_model.sv
// Host model: drives chip select, the serial clock and the control input.
// Assumes the bench calls frame; the clock stands low between frames.
`timescale 1ns/1ps
module tadc_host_model (
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      din_o,
   input  wire logic dout_i,
   input  wire logic dout_oe_i,
   input  wire logic busy_i,
   input  wire logic busy_oe_i,
   input  wire logic track_i
);
   localparam int HALF = 40;

   // Idle state: clock still, select high.
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o  = 1'b0;
   end

   // Outside frames the control line carries a changing pattern.
   always begin
      #(HALF);
      if (cs_n_o) begin
         din_o = ~din_o;
      end
   end

   // One frame: leading lows, start bit, control word, then free clocks.
   // Outputs are sampled HALF/2 after each fall, a quarter of the way through the low phase.
   task automatic frame(input int lead, input logic [6:0] ctrl,
                        input int nfall, output logic [23:1] dq,
                        output logic [23:1] trk, output logic [23:1] bsy,
                        output logic oe_ok);
      int k;
      dq    = '0;
      trk   = '0;
      bsy   = '0;
      oe_ok = 1'b1;
      #13;
      cs_n_o = 1'b0;
      for (k = -lead; k < nfall; k++) begin
         if (k < 0) begin
            din_o = 1'b0;
         end else if (k == 0) begin
            din_o = 1'b1;
         end else if (k <= 7) begin
            din_o = ctrl[7-k];
         end else begin
            din_o = ~din_o;
         end
         #(HALF);
         sclk_o = 1'b1;
         #(HALF);
         sclk_o = 1'b0;
         #(HALF/2);
         if (k >= 0) begin
            dq[k+1]  = dout_i;
            trk[k+1] = track_i;
            bsy[k+1] = busy_i;
            oe_ok    = oe_ok & dout_oe_i & busy_oe_i;
         end
         #(HALF/2);
      end
      #(HALF);
      cs_n_o = 1'b1;
      #(HALF);
   endtask
endmodule

// File: sim/touch_adc_serial_port_bench.sv
// Self-checking bench for the touch ADC serial port.
// Assumes the host model runs frames while the bench feeds samples.
`timescale 1ns/1ps
module touch_adc_serial_port_bench;
   logic        clk_sys_i;
   logic        nrst_i;
   logic        pen;
   logic [11:0] sample;
   logic        valid;
   wire         sclk;
   wire         cs_n;
   wire         din;
   logic        dout;
   logic        dout_oe;
   logic        busy;
   logic        busy_oe;
   logic        irq_n;
   logic        irq_oe;
   logic        ready;
   logic        track;
   logic [2:0]  addr;
   logic        ser;
   logic        mode;
   logic [1:0]  pd;
   logic        strobe;
   logic [6:0]  got_ctrl;
   int          strobes = 0;
   int          errors  = 0;
   int          compares = 0;
   int          seed = 32'h5DF9B8EC;
   wire         pen_line = irq_oe ? irq_n : 1'b1;

   tadc_serial_port dut_u (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .host_serial_clock_i(sclk), .chip_select_n_i(cs_n),
      .serial_din_i(din), .serial_dout_o(dout),
      .serial_dout_oe_o(dout_oe), .busy_o(busy), .busy_oe_o(busy_oe),
      .touch_detect_irq_n_o(irq_n), .touch_detect_irq_n_oe_o(irq_oe),
      .pen_touch_i(pen), .adc_sample_i(sample),
      .adc_sample_valid_i(valid), .adc_sample_ready_o(ready),
      .track_hold_o(track), .channel_addr_o(addr),
      .single_ended_select_o(ser), .low_res_mode_o(mode),
      .power_mode_o(pd), .ctrl_strobe_o(strobe)
   );

   tadc_host_model host_u (
      .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout),
      .dout_oe_i(dout_oe), .busy_i(busy), .busy_oe_i(busy_oe),
      .track_i(track)
   );

   // System clock.
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Records every control word handed to the system side.
   always @(posedge clk_sys_i) begin
      if (strobe === 1'b1) begin
         got_ctrl <= {addr, mode, ser, pd};
         strobes  <= strobes + 1;
      end
   end

   // Result bits expected after falling edges 9 to 20, MSB first, then zeros to 23.
   function automatic logic [23:9] exp_dout(input logic [11:0] s);
      logic [23:9] r;
      int          i;
      r = '0;
      for (i = 0; i < 12; i++) begin
         r[9+i] = s[11-i];
      end
      return r;
   endfunction

   // A level expected high after falling edges first to first+len-1.
   function automatic logic [23:1] exp_phase(input int first, input int len);
      logic [23:1] r;
      int          f;
      for (f = 1; f <= 23; f++) begin
         r[f] = (f >= first) && (f < first + len);
      end
      return r;
   endfunction

   // Counts one comparison and reports it when it went wrong.
   task automatic chk(input logic bad, input string msg);
      compares++;
      if (bad !== 1'b0) begin
         errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   // Hands one sample word to the port once it is ready.
   task automatic load(input logic [11:0] s);
      int n;
      n = 0;
      @(negedge clk_sys_i);
      while (ready !== 1'b1 && n < 100) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk(ready !== 1'b1, "sample port never ready");
      sample = s;
      valid  = 1'b1;
      @(negedge clk_sys_i);
      valid  = 1'b0;
      sample = 12'($random(seed));
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      #200000;
      $display("mismatch at %0t: watchdog expired", $time);
      errors++;
      tally_and_finish();
   end

   // Main sequence: reset, pen line, then corner and random frames.
   initial begin
      logic [11:0] corner [4];
      logic [11:0] s;
      logic [6:0]  ctrl;
      logic [23:1] dq;
      logic [23:1] trk;
      logic [23:1] bsy;
      logic        ok;
      int          i;
      int          lead;
      int          nframes;
      corner  = '{12'h000, 12'hFFF, 12'h800, 12'h001};
      nframes = 0;
      nrst_i  = 1'b0;
      pen     = 1'b0;
      valid   = 1'b0;
      sample  = 12'h000;
      repeat (4) @(negedge clk_sys_i);
      nrst_i = 1'b1;
      @(negedge clk_sys_i);
      chk(dout_oe !== 1'b0 || busy_oe !== 1'b0, "enables idle");
      chk(ready !== 1'b1, "ready after reset");
      pen = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      chk(irq_oe !== 1'b1 || pen_line !== 1'b0, "pen not pulled");
      pen = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      chk(irq_oe !== 1'b0 || pen_line !== 1'b1, "pen not freed");
      for (i = 0; i < 10; i++) begin
         s    = (i < 4) ? corner[i] : 12'($random(seed));
         ctrl = 7'($random(seed));
         lead = 4 + ($random(seed) & 3);
         load(s);
         if (i == 5) begin
            // A frame cut off by chip select in mid-result.
            host_u.frame(lead, ctrl, 12, dq, trk, bsy, ok);
            nframes++;
            chk(dout_oe !== 1'b0 || busy_oe !== 1'b0, "abort");
         end
         host_u.frame(lead, ctrl, 23, dq, trk, bsy, ok);
         nframes++;
         chk(ok !== 1'b1, "enables dropped in frame");
         chk(dq[23:9] !== exp_dout(s), "result bits");
         chk(trk !== exp_phase(5, 3), "acquisition window");
         chk(bsy !== exp_phase(8, 1), "busy pulse");
         chk(dout_oe !== 1'b0 || busy_oe !== 1'b0, "enables");
         repeat (8) @(negedge clk_sys_i);
         chk(got_ctrl !== ctrl, "ctrl");
         chk(strobes != nframes, "ctrl count");
      end
      tally_and_finish();
   end
endmodule
